// ==== include/gafm_pkg.sv ====
// Constants, encodings and reset tables for the pin function multiplexer.
// Assumes a 16-bit register port with 8-bit register addresses.
package gafm_pkg;

  // Geometry
  localparam int PIN_COUNT = 13;
  localparam int CODE_W = 4;
  localparam int PINS_PER_REG = 4;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;

  // Register addresses
  localparam logic [7:0] ADDR_FN_A = 8'h8C;
  localparam logic [7:0] ADDR_FN_B = 8'h8D;
  localparam logic [7:0] ADDR_FN_C = 8'h8E;
  localparam logic [7:0] ADDR_FN_D = 8'h8F;
  localparam logic [7:0] ADDR_PIN_STATUS = 8'h1E;
  localparam logic [7:0] ADDR_SYS_IRQ = 8'h18;

  // Field values
  localparam logic [3:0] CODE_GPIO = 4'h0;
  localparam logic [15:0] FN_D_MASK = 16'h000F;
  localparam int SYS_IRQ_PIN_BIT = 0;

  // Control interface modes
  typedef enum logic [1:0] {
    GAFM_CTRL_2WIRE = 2'b00,
    GAFM_CTRL_3WIRE = 2'b01,
    GAFM_CTRL_4WIRE = 2'b10
  } gafm_ctrl_mode_e;

  // Pins forced by the control interface
  localparam int PIN_SELECT = 7;
  localparam int PIN_SERIAL_OUT = 6;

  // Output function identifiers (index into the source vector)
  typedef enum logic [4:0] {
    OF_NONE = 5'h00, OF_POWER_ON_IND = 5'h01, OF_BACKUP_SUPPLY = 5'h02,
    OF_POWER_UP_FLAG = 5'h03, OF_SYS_RESET_N = 5'h04, OF_CONFIG_WINDOW = 5'h05,
    OF_MEMORY_RESET_N = 5'h06, OF_SLOW_CLOCK = 5'h07, OF_PHASE_CLOCK = 5'h08,
    OF_AUX_READY = 5'h09, OF_STROBE_ACTIVE = 5'h0A, OF_SUPPLY_FAULT_N = 5'h0B,
    OF_MIC_SHORT = 5'h0C, OF_MIC_DETECT = 5'h0D, OF_ADC_FRAME = 5'h0E,
    OF_ADC_FRAME_INV = 5'h0F, OF_BATTERY_FAULT_N = 5'h10, OF_CODEC_CLOCK = 5'h11,
    OF_CAL_SQUARE = 5'h12, OF_ADC_BIT = 5'h13, OF_LINE_ABOVE_BATT = 5'h14,
    OF_LED_SINK_C = 5'h15, OF_LED_SINK_D = 5'h16, OF_LED_SINK_E = 5'h17,
    OF_CHARGE_IND = 5'h18, OF_WALL_SWITCH = 5'h19
  } gafm_out_fn_e;
  localparam int OUT_FN_COUNT = 26;

  // Input function identifiers (index into the routed input vector)
  typedef enum logic [4:0] {
    IF_NONE = 5'h00, IF_POWER_ON_REQ = 5'h01, IF_REG1_ENABLE_N = 5'h02,
    IF_LOW_POWER_1 = 5'h03, IF_LOW_POWER_2 = 5'h04, IF_LOW_POWER_3 = 5'h05,
    IF_POWER_OFF_REQ = 5'h06, IF_CHIP_RESET = 5'h07, IF_WAKE_N = 5'h08,
    IF_SLOW_CLOCK = 5'h09, IF_STROBE_TRIG = 5'h0A, IF_MANUAL_RESET_N = 5'h0B,
    IF_SLEEP_LEVEL = 5'h0C, IF_SLEEP_EDGE = 5'h0D, IF_AUX_MASK = 5'h0E,
    IF_ADC_FRAME = 5'h0F, IF_ADC_BIT = 5'h10, IF_WATCHDOG_KICK = 5'h11
  } gafm_in_fn_e;
  localparam int IN_FN_COUNT = 18;

  // Idle level of routed inputs (active-low ones high)
  localparam logic [17:0] IN_FN_IDLE = 18'h00904;

  // Reset codes per configuration mode, pin 0 in the low nibble
  localparam int CFG_MODES = 4;
  localparam logic [51:0] CFG_DEFAULTS [CFG_MODES] = '{
    52'h0000000000000,
    52'h0000000000211,
    52'h0000000031011,
    52'h0000000000000
  };

endpackage

// ==== hw/gafm_pin_cell.sv ====
// Function decode for one pin: code and direction to routed function identifiers.
// Assumes the caller handles overrides and plain GPIO.
module gafm_pin_cell #(
  parameter int PIN = 0
) (
  // Pin configuration
  input wire logic [3:0] pin_function_code,
  input wire logic pin_direction,
  // Decoded selection
  output gafm_pkg::gafm_in_fn_e in_fn,
  output gafm_pkg::gafm_out_fn_e out_fn
);

  gafm_pkg::gafm_in_fn_e in_sel;
  gafm_pkg::gafm_out_fn_e out_sel;

  // Per-pin tables; unlisted codes select nothing
  always_comb
  begin
    in_sel = gafm_pkg::IF_NONE;
    out_sel = gafm_pkg::OF_NONE;
    case (PIN)
      0:
      begin
        case (pin_function_code)
          4'h1: begin in_sel = gafm_pkg::IF_POWER_ON_REQ; out_sel = gafm_pkg::OF_POWER_ON_IND; end
          4'h2: begin in_sel = gafm_pkg::IF_REG1_ENABLE_N; out_sel = gafm_pkg::OF_BACKUP_SUPPLY; end
          4'h3: begin in_sel = gafm_pkg::IF_LOW_POWER_1; out_sel = gafm_pkg::OF_POWER_UP_FLAG; end
          4'h4: begin in_sel = gafm_pkg::IF_POWER_OFF_REQ; out_sel = gafm_pkg::OF_SYS_RESET_N; end
          4'h5: in_sel = gafm_pkg::IF_CHIP_RESET;
          default: ;
        endcase
      end
      1:
      begin
        case (pin_function_code)
          4'h1: begin in_sel = gafm_pkg::IF_POWER_ON_REQ; out_sel = gafm_pkg::OF_CONFIG_WINDOW; end
          4'h2: begin in_sel = gafm_pkg::IF_REG1_ENABLE_N; out_sel = gafm_pkg::OF_SYS_RESET_N; end
          4'h3: begin in_sel = gafm_pkg::IF_LOW_POWER_2; out_sel = gafm_pkg::OF_MEMORY_RESET_N; end
          4'h4: begin in_sel = gafm_pkg::IF_WAKE_N; out_sel = gafm_pkg::OF_SLOW_CLOCK; end
          default: ;
        endcase
      end
      2:
      begin
        case (pin_function_code)
          4'h1: begin in_sel = gafm_pkg::IF_POWER_ON_REQ; out_sel = gafm_pkg::OF_POWER_ON_IND; end
          4'h2: begin in_sel = gafm_pkg::IF_WAKE_N; out_sel = gafm_pkg::OF_BACKUP_SUPPLY; end
          4'h3: begin in_sel = gafm_pkg::IF_SLOW_CLOCK; out_sel = gafm_pkg::OF_SLOW_CLOCK; end
          4'h4: begin in_sel = gafm_pkg::IF_LOW_POWER_3; out_sel = gafm_pkg::OF_SYS_RESET_N; end
          default: ;
        endcase
      end
      3:
      begin
        case (pin_function_code)
          4'h1: begin in_sel = gafm_pkg::IF_POWER_ON_REQ; out_sel = gafm_pkg::OF_PHASE_CLOCK; end
          4'h2: begin in_sel = gafm_pkg::IF_REG1_ENABLE_N; out_sel = gafm_pkg::OF_BACKUP_SUPPLY; end
          4'h3: begin in_sel = gafm_pkg::IF_POWER_OFF_REQ; out_sel = gafm_pkg::OF_SLOW_CLOCK; end
          4'h4: begin in_sel = gafm_pkg::IF_STROBE_TRIG; out_sel = gafm_pkg::OF_MEMORY_RESET_N; end
          default: ;
        endcase
      end
      4:
      begin
        case (pin_function_code)
          4'h1: begin in_sel = gafm_pkg::IF_MANUAL_RESET_N; out_sel = gafm_pkg::OF_MEMORY_RESET_N; end
          4'h2: begin in_sel = gafm_pkg::IF_STROBE_TRIG; out_sel = gafm_pkg::OF_AUX_READY; end
          4'h3: begin in_sel = gafm_pkg::IF_SLEEP_LEVEL; out_sel = gafm_pkg::OF_STROBE_ACTIVE; end
          4'h4: begin in_sel = gafm_pkg::IF_AUX_MASK; out_sel = gafm_pkg::OF_SUPPLY_FAULT_N; end
          4'h5: begin in_sel = gafm_pkg::IF_CHIP_RESET; out_sel = gafm_pkg::OF_MIC_SHORT; end
          4'hA: out_sel = gafm_pkg::OF_MIC_DETECT;
          default: ;
        endcase
      end
      5:
      begin
        case (pin_function_code)
          4'h1: begin in_sel = gafm_pkg::IF_LOW_POWER_1; out_sel = gafm_pkg::OF_PHASE_CLOCK; end
          4'h2: begin in_sel = gafm_pkg::IF_ADC_FRAME; out_sel = gafm_pkg::OF_ADC_FRAME; end
          4'h3: begin in_sel = gafm_pkg::IF_SLEEP_EDGE; out_sel = gafm_pkg::OF_SLOW_CLOCK; end
          4'h4: begin in_sel = gafm_pkg::IF_POWER_OFF_REQ; out_sel = gafm_pkg::OF_BATTERY_FAULT_N; end
          4'h5: begin in_sel = gafm_pkg::IF_SLEEP_LEVEL; out_sel = gafm_pkg::OF_MIC_SHORT; end
          4'h6: out_sel = gafm_pkg::OF_AUX_READY;
          4'h7: out_sel = gafm_pkg::OF_CODEC_CLOCK;
          4'hA: out_sel = gafm_pkg::OF_MIC_DETECT;
          default: ;
        endcase
      end
      6:
      begin
        case (pin_function_code)
          4'h1: begin in_sel = gafm_pkg::IF_LOW_POWER_2; out_sel = gafm_pkg::OF_MEMORY_RESET_N; end
          4'h2: begin in_sel = gafm_pkg::IF_STROBE_TRIG; out_sel = gafm_pkg::OF_AUX_READY; end
          4'h3: begin in_sel = gafm_pkg::IF_SLEEP_EDGE; out_sel = gafm_pkg::OF_CAL_SQUARE; end
          4'h4: begin in_sel = gafm_pkg::IF_SLEEP_LEVEL; out_sel = gafm_pkg::OF_MIC_DETECT; end
          4'h5: out_sel = gafm_pkg::OF_MIC_SHORT;
          4'h6: out_sel = gafm_pkg::OF_ADC_FRAME_INV;
          default: ;
        endcase
      end
      7:
      begin
        case (pin_function_code)
          4'h1: begin in_sel = gafm_pkg::IF_LOW_POWER_3; out_sel = gafm_pkg::OF_PHASE_CLOCK; end
          4'h2: begin in_sel = gafm_pkg::IF_AUX_MASK; out_sel = gafm_pkg::OF_SUPPLY_FAULT_N; end
          4'h3: begin in_sel = gafm_pkg::IF_SLEEP_LEVEL; out_sel = gafm_pkg::OF_BATTERY_FAULT_N; end
          4'h4: out_sel = gafm_pkg::OF_MIC_DETECT;
          4'h5: out_sel = gafm_pkg::OF_MIC_SHORT;
          4'h6: out_sel = gafm_pkg::OF_AUX_READY;
          default: ;
        endcase
      end
      8:
      begin
        case (pin_function_code)
          4'h1: begin in_sel = gafm_pkg::IF_MANUAL_RESET_N; out_sel = gafm_pkg::OF_SUPPLY_FAULT_N; end
          4'h2: begin in_sel = gafm_pkg::IF_ADC_BIT; out_sel = gafm_pkg::OF_ADC_BIT; end
          4'h3: begin in_sel = gafm_pkg::IF_POWER_OFF_REQ; out_sel = gafm_pkg::OF_BATTERY_FAULT_N; end
          4'h4: begin in_sel = gafm_pkg::IF_SLEEP_EDGE; out_sel = gafm_pkg::OF_SYS_RESET_N; end
          default: ;
        endcase
      end
      9:
      begin
        case (pin_function_code)
          4'h1: begin in_sel = gafm_pkg::IF_WATCHDOG_KICK; out_sel = gafm_pkg::OF_SUPPLY_FAULT_N; end
          4'h2: begin in_sel = gafm_pkg::IF_AUX_MASK; out_sel = gafm_pkg::OF_LINE_ABOVE_BATT; end
          4'h3: begin in_sel = gafm_pkg::IF_POWER_OFF_REQ; out_sel = gafm_pkg::OF_BATTERY_FAULT_N; end
          4'h4: begin in_sel = gafm_pkg::IF_SLEEP_LEVEL; out_sel = gafm_pkg::OF_MEMORY_RESET_N; end
          default: ;
        endcase
      end
      10, 11:
      begin
        case (pin_function_code)
          4'h1: out_sel = (PIN == 10) ? gafm_pkg::OF_LED_SINK_C : gafm_pkg::OF_LED_SINK_D;
          4'h2:
          begin
            out_sel = gafm_pkg::OF_LINE_ABOVE_BATT;
            if (PIN == 11)
              in_sel = gafm_pkg::IF_WAKE_N;
          end
          4'h3:
          begin
            out_sel = gafm_pkg::OF_CHARGE_IND;
            if (PIN == 10)
              in_sel = gafm_pkg::IF_POWER_OFF_REQ;
          end
          default: ;
        endcase
      end
      default:
      begin
        case (pin_function_code)
          4'h1: begin in_sel = gafm_pkg::IF_CHIP_RESET; out_sel = gafm_pkg::OF_LED_SINK_E; end
          4'h2: out_sel = gafm_pkg::OF_LINE_ABOVE_BATT;
          4'h3: out_sel = gafm_pkg::OF_WALL_SWITCH;
          4'h4: out_sel = gafm_pkg::OF_SLOW_CLOCK;
          default: ;
        endcase
      end
    endcase
  end

  // Direction picks the column
  assign in_fn = pin_direction ? in_sel : gafm_pkg::IF_NONE;
  assign out_fn = pin_direction ? gafm_pkg::OF_NONE : out_sel;

endmodule

// ==== hw/gafm_evt_flags.sv ====
// Sticky pin event flags with read-to-clear and an interrupt request level.
// Assumes one-cycle read strobes from the register port.
module gafm_evt_flags #(
  parameter int WIDTH = 13
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Events and reads
  input wire logic [WIDTH-1:0] event_in,
  input wire logic status_read,
  input wire logic system_read,
  // State
  output logic [WIDTH-1:0] status_q,
  output logic irq_q
);

  logic [WIDTH-1:0] status_d;
  logic irq_d;

  // New events win over a clear in the same cycle
  always_comb
  begin
    status_d = (status_q & ~{WIDTH{status_read}}) | event_in;
    irq_d = irq_q;
    if (|event_in)
      irq_d = 1'b1;
    else if (system_read)
      irq_d = 1'b0;
  end

  // Flag registers
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      status_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      status_q <= status_d;
      irq_q <= irq_d;
    end
  end

endmodule

// ==== hw/gafm_mux.sv ====
// Pin function multiplexer for thirteen general-purpose pins.
// Assumes a synchronous 16-bit register port from the serial control interface
// and alternate function sources and sinks elsewhere in the device.
//
// Function
// - Code zero gives plain GPIO, others alternates
// - Direction bit selects input or output column
// - Pin status read returns events, clears them
// - System interrupt read drops the request
// - Three/four-wire mode forces pin 7 select
// - Four-wire mode forces pin 6 serial out
// - Four codes per register (one in the last), pins in nibbles
// - Pin 0 function table
// - Pin 1 function table
// - Pin 2 function table
// - Pin 3 function table
// - Pin 4 function table
// - Pin 5 function table
// - Pin 6 function table
// - Pin 7 function table
// - Pin 8 function table
// - Pin 9 function table
// - Pins 10 and 11 function tables
// - Pin 12 function table
module gafm_mux #(
  parameter int PINS = gafm_pkg::PIN_COUNT
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Strap and mode levels
  input wire logic [1:0] config_mode,
  input wire logic [1:0] ctrl_mode,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  output logic irq_q,
  // Per-pin configuration levels
  input wire logic [PINS-1:0] pin_direction,
  // Plain GPIO side
  input wire logic [PINS-1:0] gpio_out,
  output logic [PINS-1:0] gpio_in,
  // Alternate function sources and routed inputs
  input wire logic [gafm_pkg::OUT_FN_COUNT-1:0] alt_out_src,
  output logic [gafm_pkg::IN_FN_COUNT-1:0] alt_in,
  // Control interface pins
  input wire logic ctrl_serial_out,
  output logic ctrl_select_n,
  // Pads
  input wire logic [PINS-1:0] pad_in,
  output logic [PINS-1:0] pad_out,
  output logic [PINS-1:0] pad_oe
);

  localparam int CODE_W = gafm_pkg::CODE_W;

  // Function code store and its next value
  logic [PINS-1:0][CODE_W-1:0] fn_q;
  logic [PINS-1:0][CODE_W-1:0] fn_d;
  logic loaded_q;
  logic loaded_d;

  // Decoded selections
  gafm_pkg::gafm_in_fn_e in_fn [PINS];
  gafm_pkg::gafm_out_fn_e out_fn [PINS];

  // Pin state next values
  logic [PINS-1:0] pad_out_d;
  logic [PINS-1:0] pad_oe_d;
  logic [PINS-1:0] gpio_in_d;
  logic [gafm_pkg::IN_FN_COUNT-1:0] alt_in_d;
  logic ctrl_select_n_d;
  logic [PINS-1:0] pad_in_q;
  logic [PINS-1:0] pin_event;

  // Register port next values
  logic [15:0] reg_rdata_d;
  logic reg_rvalid_d;
  logic [PINS-1:0] status_q;
  logic status_read;
  logic system_read;

  // Control-interface overrides
  logic force_select;
  logic force_serial;

  assign force_select = (ctrl_mode == gafm_pkg::GAFM_CTRL_3WIRE) ||
                        (ctrl_mode == gafm_pkg::GAFM_CTRL_4WIRE);
  assign force_serial = (ctrl_mode == gafm_pkg::GAFM_CTRL_4WIRE);

  // Per-pin decode
  for (genvar p = 0; p < PINS; p++)
  begin : g_cell
    gafm_pin_cell #(
      .PIN(p)
    ) u_cell (
      .pin_function_code(fn_q[p]),
      .pin_direction(pin_direction[p]),
      .in_fn(in_fn[p]),
      .out_fn(out_fn[p])
    );
  end

  // Function code store: strap load after reset, then register writes
  always_comb
  begin
    fn_d = fn_q;
    loaded_d = 1'b1;
    if (!loaded_q)
    begin
      fn_d = gafm_pkg::CFG_DEFAULTS[config_mode][PINS*CODE_W-1:0];
    end
    else if (reg_write)
    begin
      for (int r = 0; r < PINS; r++)
      begin
        if (reg_addr == gafm_pkg::ADDR_FN_A + 8'(r / gafm_pkg::PINS_PER_REG))
          fn_d[r] = reg_wdata[(r % gafm_pkg::PINS_PER_REG)*CODE_W +: CODE_W];
      end
    end
  end

  // Code registers start cleared; the strap value lands one edge after release
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      fn_q <= '0;
      loaded_q <= 1'b0;
    end
    else
    begin
      fn_q <= fn_d;
      loaded_q <= loaded_d;
    end
  end

  // Pad drive, routed inputs and forced control-interface pins
  always_comb
  begin
    pad_out_d = '0;
    pad_oe_d = '0;
    gpio_in_d = pad_in;
    alt_in_d = gafm_pkg::IN_FN_IDLE;
    ctrl_select_n_d = 1'b1;
    for (int p = PINS - 1; p >= 0; p--)
    begin
      if (force_select && p == gafm_pkg::PIN_SELECT)
      begin
        ctrl_select_n_d = pad_in[p];
      end
      else if (force_serial && p == gafm_pkg::PIN_SERIAL_OUT)
      begin
        pad_out_d[p] = ctrl_serial_out;
        pad_oe_d[p] = 1'b1;
      end
      else if (fn_q[p] == gafm_pkg::CODE_GPIO)
      begin
        pad_out_d[p] = gpio_out[p];
        pad_oe_d[p] = ~pin_direction[p];
      end
      else if (out_fn[p] == gafm_pkg::OF_LED_SINK_C ||
               out_fn[p] == gafm_pkg::OF_LED_SINK_D ||
               out_fn[p] == gafm_pkg::OF_LED_SINK_E)
      begin
        pad_out_d[p] = 1'b0; // Open drain: only pulls low
        pad_oe_d[p] = alt_out_src[out_fn[p]];
      end
      else if (out_fn[p] != gafm_pkg::OF_NONE)
      begin
        pad_out_d[p] = alt_out_src[out_fn[p]];
        pad_oe_d[p] = 1'b1;
      end
      else if (in_fn[p] != gafm_pkg::IF_NONE)
      begin
        alt_in_d[in_fn[p]] = pad_in[p]; // Lowest pin wins a shared input
      end
    end
  end

  // Pin state registers
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pad_out <= '0;
      pad_oe <= '0;
      gpio_in <= '0;
      alt_in <= gafm_pkg::IN_FN_IDLE;
      ctrl_select_n <= 1'b1;
      pad_in_q <= '0;
    end
    else
    begin
      pad_out <= pad_out_d;
      pad_oe <= pad_oe_d;
      gpio_in <= gpio_in_d;
      alt_in <= alt_in_d;
      ctrl_select_n <= ctrl_select_n_d;
      pad_in_q <= pad_in;
    end
  end

  // Events: any change on a pin configured as input, once codes are loaded
  assign pin_event = loaded_q ? ((pad_in ^ pad_in_q) & pin_direction) : '0;
  assign status_read = reg_read && (reg_addr == gafm_pkg::ADDR_PIN_STATUS);
  assign system_read = reg_read && (reg_addr == gafm_pkg::ADDR_SYS_IRQ);

  // Sticky flags and request level
  gafm_evt_flags #(
    .WIDTH(PINS)
  ) u_flags (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .event_in(pin_event),
    .status_read(status_read),
    .system_read(system_read),
    .status_q(status_q),
    .irq_q(irq_q)
  );

  // Read decode; unmapped addresses read zero
  always_comb
  begin
    reg_rdata_d = '0;
    reg_rvalid_d = reg_read;
    if (reg_addr == gafm_pkg::ADDR_FN_A)
      reg_rdata_d = {fn_q[3], fn_q[2], fn_q[1], fn_q[0]};
    else if (reg_addr == gafm_pkg::ADDR_FN_B)
      reg_rdata_d = {fn_q[7], fn_q[6], fn_q[5], fn_q[4]};
    else if (reg_addr == gafm_pkg::ADDR_FN_C)
      reg_rdata_d = {fn_q[11], fn_q[10], fn_q[9], fn_q[8]};
    else if (reg_addr == gafm_pkg::ADDR_FN_D)
      reg_rdata_d = {12'h000, fn_q[12]} & gafm_pkg::FN_D_MASK;
    else if (reg_addr == gafm_pkg::ADDR_PIN_STATUS)
      reg_rdata_d = 16'(status_q);
    else if (reg_addr == gafm_pkg::ADDR_SYS_IRQ)
      reg_rdata_d[gafm_pkg::SYS_IRQ_PIN_BIT] = irq_q;
    if (!reg_read)
      reg_rdata_d = '0;
  end

  // Read data registers
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      reg_rdata <= '0;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rdata <= reg_rdata_d;
      reg_rvalid <= reg_rvalid_d;
    end
  end

endmodule

// ==== test/gafm_mux_asserts.sv ====
// Port-level assertions for the pin function multiplexer.
// Assumes one clock domain and the asynchronous active-high reset.
module gafm_mux_asserts #(
  parameter int PINS = 13
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic irq_q,
  // Pins and control interface
  input wire logic [1:0] ctrl_mode,
  input wire logic [PINS-1:0] pin_direction,
  input wire logic ctrl_serial_out,
  input wire logic ctrl_select_n,
  input wire logic [PINS-1:0] pad_in,
  input wire logic [PINS-1:0] pad_out,
  input wire logic [PINS-1:0] pad_oe
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  // Pads unchanged over three edges
  sequence s_quiet;
    $stable(pad_in)[*3];
  endsequence
  // Host reads the system interrupt register
  sequence s_irq_read;
    reg_read && reg_addr == gafm_pkg::ADDR_SYS_IRQ;
  endsequence
  // An input-direction pad changed level
  sequence s_pin_event;
    |((pad_in ^ $past(pad_in)) & pin_direction);
  endsequence

  a_read_answers: assert property (reg_read |=> reg_rvalid)
    else $error("read got no answer");
  a_idle_silent: assert property (!reg_read |=> !reg_rvalid && reg_rdata == 16'h0000)
    else $error("answer without read");
  a_fn_d_narrow: assert property (reg_read && reg_addr == gafm_pkg::ADDR_FN_D
    |=> reg_rdata[15:4] == 12'h000) else $error("upper register bits not zero");
  a_unmapped_zero: assert property (reg_read && !(reg_addr inside {[8'h8C:8'h8F],
    8'h1E, 8'h18}) |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
  a_irq_readout: assert property (s_irq_read |=> reg_rdata == {15'h0000, $past(irq_q)})
    else $error("interrupt read data wrong");
  a_event_raises: assert property (s_pin_event |=> irq_q)
    else $error("pin event did not raise request");
  a_irq_drops: assert property (s_quiet ##0 s_irq_read |=> ##[0:1] !irq_q)
    else $error("request not dropped on read");
  a_select_forced: assert property (ctrl_mode inside {2'd1, 2'd2} |=>
    ctrl_select_n == $past(pad_in[7]) && !pad_oe[7]) else $error("select pin not forced");
  a_select_idle: assert property (ctrl_mode inside {2'd0, 2'd3} |=> ctrl_select_n)
    else $error("select active in two-wire mode");
  a_ctrl_serial_out_forced: assert property (ctrl_mode == 2'd2 |=>
    pad_oe[6] && pad_out[6] == $past(ctrl_serial_out)) else $error("serial out not forced");
endmodule

bind gafm_mux gafm_mux_asserts #(.PINS(PINS)) gafm_mux_asserts_inst (.core_clk, .sys_rst,
  .reg_addr, .reg_read, .reg_rdata, .reg_rvalid, .irq_q, .ctrl_mode, .pin_direction,
  .ctrl_serial_out, .ctrl_select_n, .pad_in, .pad_out, .pad_oe);

// ==== test/gafm_host_model.sv ====
// Host model: register port driver with a shadow of pin codes.
// Assumes requests launch on the falling edge of core_clk.
module gafm_host_model (
  // Clock
  input wire logic core_clk,
  // Register port
  output logic [7:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_write,
  output logic reg_read,
  // Direction levels
  output logic [12:0] pin_direction
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] code [13];

  // Quiet port at time zero
  initial
  begin
    {reg_addr, reg_wdata, reg_write, reg_read, pin_direction} = 39'h0;
  end

  // One-cycle strobe, then scrambled address and data
  task automatic cyc(input logic [7:0] a, input logic [15:0] d, input logic w);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_write = w;
    reg_read = !w;
    @(negedge core_clk);
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  // Register image from the shadow
  function automatic logic [15:0] img(input int r);
    logic [15:0] v;
    v = 16'h0000;
    for (int i = 0; i < 4; i++)
      if (4 * r + i < 13)
        v[4*i +: 4] = code[4*r + i];
    return v;
  endfunction

  // Shadow follows the strap after reset
  task automatic load(input int m);
    for (int i = 0; i < 13; i++)
      code[i] = gafm_pkg::CFG_DEFAULTS[m][4*i +: 4];
  endtask

  // Park at zero, set direction, then new code
  task automatic set_fn(input int p, input logic [3:0] c, input logic d);
    code[p] = 4'h0;
    cyc(gafm_pkg::ADDR_FN_A + 8'(p / 4), img(p / 4), 1'b1);
    pin_direction[p] = d;
    code[p] = c;
    cyc(gafm_pkg::ADDR_FN_A + 8'(p / 4), img(p / 4), 1'b1);
  endtask
endmodule

// ==== test/test_gafm_mux.sv ====
// Self-checking bench for the pin function multiplexer.
// Assumes the host model drives the register port and directions.
module test_gafm_mux;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, sys_rst, reg_write, reg_read, reg_rvalid, irq_q;
  logic ctrl_serial_out, ctrl_select_n;
  logic [1:0] config_mode, ctrl_mode;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [12:0] pin_direction, gpio_out, gpio_in, pad_in, pad_out, pad_oe, ev;
  logic [25:0] alt_out_src;
  logic [17:0] alt_in;
  logic [15:0] exp_q [$];
  int failures = 0;
  int n_tests = 0;
  // Pin, code, function index
  logic [15:0] out_t [13] = '{16'h0101, 16'h1407, 16'h2307, 16'h3108,
    16'h4A0D, 16'h5711, 16'h660F, 16'h7609, 16'h8213,
    16'h9214, 16'hA318, 16'hB214, 16'hC319};
  logic [15:0] in_t [10] = '{16'h0101, 16'h1304, 16'h2309, 16'h410B,
    16'h520F, 16'h8210, 16'h9111, 16'hA306, 16'hB208, 16'hC107};

  gafm_mux gafm_mux_inst (.core_clk, .sys_rst, .config_mode, .ctrl_mode, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .reg_rvalid, .irq_q, .pin_direction, .gpio_out, .gpio_in,
    .alt_out_src, .alt_in, .ctrl_serial_out, .ctrl_select_n, .pad_in, .pad_out, .pad_oe);
  gafm_host_model gafm_host_model_inst (.core_clk, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .pin_direction);

  // Clock
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic chk(input string s, input logic [25:0] e, g);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic end_of_test();
    if (exp_q.size() != 0)
      failures++;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Let two edges settle registered outputs
  task automatic settle();
    repeat (2) @(negedge core_clk);
  endtask

  // Note the answer, then read
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    gafm_host_model_inst.cyc(a, 16'h0000, 1'b0);
  endtask

  // Drive a pad, noting input events
  task automatic pad(input int p, input logic v);
    @(negedge core_clk);
    if (pin_direction[p] && pad_in[p] !== v)
      ev[p] = 1'b1;
    pad_in[p] = v;
  endtask

  // Reset with a strap value
  task automatic rst(input logic [1:0] m);
    @(negedge core_clk);
    sys_rst = 1'b1;
    config_mode = m;
    gafm_host_model_inst.load(m);
    repeat (16) @(negedge core_clk);
    sys_rst = 1'b0;
    settle();
  endtask

  task automatic readback();
    for (int r = 0; r < 4; r++)
      rd(gafm_pkg::ADDR_FN_A + 8'(r), gafm_host_model_inst.img(r));
  endtask

  // Match each answer to the oldest note
  always @(negedge core_clk)
    if (reg_rvalid === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk("reg_rvalid", 26'h0, 26'h1);
      else
        chk("reg_rdata", exp_q.pop_front(), reg_rdata);
    end

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge core_clk);
    failures++;
    end_of_test();
  end

  // Main sequence
  initial
  begin
    int p;
    int f;
    logic b;
    sys_rst = 1'b1;
    config_mode = 2'd1;
    ctrl_mode = 2'd0;
    pad_in = 13'h0000;
    ev = 13'h0000;
    void'($urandom(56));
    gpio_out = 13'($urandom);
    alt_out_src = 26'($urandom);
    ctrl_serial_out = 1'($urandom);
    rst(2'd1);
    readback();
    $display("test reset codes done");
    foreach (out_t[i])
      gafm_host_model_inst.set_fn(out_t[i][15:12], out_t[i][11:8], 1'b0);
    for (int k = 0; k < 2; k++)
    begin
      alt_out_src = k ? ~alt_out_src : 26'($urandom);
      settle();
      chk("pad_oe", 26'h1FFF, pad_oe);
      foreach (out_t[i])
        chk("pad_out", alt_out_src[out_t[i][7:0]], pad_out[out_t[i][15:12]]);
    end
    $display("test output columns done");
    gafm_host_model_inst.set_fn(3, 4'h0, 1'b0);
    settle();
    chk("pad_out", gpio_out[3], pad_out[3]);
    gafm_host_model_inst.set_fn(3, 4'h0, 1'b1);
    pad(3, 1'b1);
    settle();
    chk("pad_oe", 26'h0, pad_oe[3]);
    chk("gpio_in", 26'h1, gpio_in[3]);
    $display("test plain pin done");
    foreach (in_t[i])
    begin
      p = in_t[i][15:12];
      f = in_t[i][7:0];
      b = gafm_pkg::IN_FN_IDLE[f];
      pad(p, b);
      gafm_host_model_inst.set_fn(p, in_t[i][11:8], 1'b1);
      settle();
      chk("alt_in", b, alt_in[f]);
      pad(p, !b);
      settle();
      chk("alt_in", !b, alt_in[f]);
    end
    $display("test input columns done");
    chk("irq_q", 26'h1, irq_q);
    rd(gafm_pkg::ADDR_PIN_STATUS, 16'(ev));
    rd(gafm_pkg::ADDR_SYS_IRQ, 16'h0001);
    @(negedge core_clk);
    chk("irq_q", 26'h0, irq_q);
    rd(gafm_pkg::ADDR_PIN_STATUS, 16'h0000);
    $display("test pin events done");
    pad(7, 1'b0);
    ctrl_mode = 2'd2;
    settle();
    chk("ctrl_select_n", 26'h0, ctrl_select_n);
    chk("pad_out", ctrl_serial_out, pad_out[6]);
    chk("pad_oe", 26'h1, pad_oe[6]);
    ctrl_mode = 2'd1;
    settle();
    chk("pad_out", alt_out_src[15], pad_out[6]);
    chk("pad_oe", 26'h0, pad_oe[7]);
    ctrl_mode = 2'd0;
    settle();
    chk("ctrl_select_n", 26'h1, ctrl_select_n);
    $display("test control modes done");
    gafm_host_model_inst.cyc(gafm_pkg::ADDR_FN_D, 16'hFFF1, 1'b1);
    gafm_host_model_inst.cyc(8'h90, 16'($urandom), 1'b1);
    rd(8'h90, 16'h0000);
    readback();
    rst(2'd2);
    readback();
    settle();
    $display("test register map done");
    end_of_test();
  end
endmodule
